// >>> common/isx_consts.vh
// Constants for the indirect store and miscellaneous instruction unit
`ifndef ISX_CONSTS_VH
`define ISX_CONSTS_VH
`define PTR_WIDTH        16
`define PTR_RESET        16'h0000
`define OPTION_RESET     8'hff
`define ADDR_RESET       16'h0000
`define DATA_RESET       8'h00
`define STATUS_RESET     8'h00
`define CAUSE_RESET      1'b1
`define ACC_WIDTH        8
`define MODE_PREINC      2'h0
`define MODE_PREDEC      2'h1
`define MODE_POSTINC     2'h2
`define MODE_POSTDEC     2'h3
`define OP_IDLE          3'h0
`define OP_STORE_MODE    3'h1
`define OP_STORE_OFFSET  3'h2
`define OP_OPTION        3'h3
`define OP_SOFT_RESET    3'h4
`endif

// >>> rtl/indirect_store_misc_instr.v
// Execution unit for indirect store, option load, software reset and idle
//
// Operation
// - Window register accesses target pointer address; this unit has no window register, only the store forms use the pointers
// - Store accumulator, update pointer per code
// - Offset form: pointer plus signed offset
// - Sixteen-bit pointer wraps at both ends
// - No status flag changes
// - Option load copies accumulator, one cycle
// - Soft reset resets device, clears cause flag
`timescale 1ns/1ps
`include "isx_consts.vh"
module indirect_store_misc_instr (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        instr_valid,
  input  wire [2:0]  instr_op,
  input  wire        ptr_sel,
  input  wire [1:0]  pointer_update_code,
  input  wire [5:0]  offset,
  input  wire [7:0]  acc,
  input  wire [7:0]  status_in,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg  [15:0] ptr0,
  output reg  [15:0] ptr1,
  output reg  [7:0]  option_reg,
  output reg  [7:0]  status_out,
  output reg         soft_reset_cause_flag,
  output reg         device_reset_req,
  output reg         done
);
  // ----------------------------------------
  // Sizing
  // ----------------------------------------
  // Two pointers; the bank and its one-hot select are sized from this
  localparam PTR_COUNT = 2;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  // Opcode match gated by the valid strobe; every strobe below shares it
  function op_hit;
    input       valid;
    input [2:0] op;
    input [2:0] code;
    begin
      op_hit = valid && (op == code);
    end
  endfunction

  // only listed opcodes act
  // Idle and undefined codes match no strobe, so they only pulse done
  wire store_mode_hit   = op_hit(instr_valid, instr_op, `OP_STORE_MODE);
  wire store_offset_hit = op_hit(instr_valid, instr_op, `OP_STORE_OFFSET);
  wire option_hit       = op_hit(instr_valid, instr_op, `OP_OPTION);
  wire soft_reset_hit   = op_hit(instr_valid, instr_op, `OP_SOFT_RESET);
  wire is_store         = store_mode_hit || store_offset_hit;
  // Form select ignores valid; the write strobe alone gates the effect
  wire offset_form      = (instr_op == `OP_STORE_OFFSET);

  // ----------------------------------------
  // Pointer bank
  // ----------------------------------------
  // Both pointers sit in one indexed pair so the update path is shared
  wire [15:0]          ptr_cur  [0:PTR_COUNT-1];
  wire [15:0]          ptr_next [0:PTR_COUNT-1];
  wire [PTR_COUNT-1:0] ptr_hit;
  wire [15:0]          cur_ptr;
  wire [15:0]          eff_addr;
  wire [15:0]          ptr_after;

  assign ptr_cur[0] = ptr0;
  assign ptr_cur[1] = ptr1;
  assign cur_ptr    = ptr_cur[ptr_sel];
  // One-hot write select; at most one pointer moves per store
  assign ptr_hit    = {is_store && ptr_sel, is_store && !ptr_sel};

  // ----------------------------------------
  // Address calculation
  // ----------------------------------------
  // Shared adder pair; only the selected pointer is ever presented
  // Post forms write at the old address, pre forms at the moved one
  ptr_adjust u_adj (
    .ptr                 (cur_ptr),
    .pointer_update_code (pointer_update_code),
    .use_offset          (offset_form),
    .offset              (offset),
    .eff_addr            (eff_addr),
    .ptr_after           (ptr_after)
  );

  genvar gi;
  generate
    for (gi = 0; gi < PTR_COUNT; gi = gi + 1) begin : g_ptr_next
      assign ptr_next[gi] = ptr_hit[gi] ? ptr_after : ptr_cur[gi];
    end
  endgenerate

  // ----------------------------------------
  // Memory write port
  // ----------------------------------------
  // Address and data hold their last values between stores, so a
  // downstream capture may sample them late without a second strobe
  reg        mem_we_next;
  reg [15:0] mem_addr_next;
  reg [7:0]  mem_wdata_next;

  always @* begin
    mem_we_next    = 1'b0;
    mem_addr_next  = mem_addr;
    mem_wdata_next = mem_wdata;
    if (is_store) begin
      mem_we_next    = 1'b1;
      mem_addr_next  = eff_addr;
      mem_wdata_next = acc;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_we    <= 1'b0;
      mem_addr  <= `ADDR_RESET;
      mem_wdata <= `DATA_RESET;
    end else begin
      mem_we    <= mem_we_next;
      mem_addr  <= mem_addr_next;
      mem_wdata <= mem_wdata_next;
    end
  end

  // ----------------------------------------
  // Pointer registers
  // ----------------------------------------
  // Pointer moves at the same edge that raises the write strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr0 <= `PTR_RESET;
      ptr1 <= `PTR_RESET;
    end else begin
      ptr0 <= ptr_next[0];
      ptr1 <= ptr_next[1];
    end
  end

  // ----------------------------------------
  // Option configuration
  // ----------------------------------------
  // Loaded value stays until the next option load or reset
  reg [7:0] option_next;

  always @* begin
    option_next = option_reg;
    if (option_hit) begin
      option_next = acc;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      option_reg <= `OPTION_RESET;
    end else begin
      option_reg <= option_next;
    end
  end

  // ----------------------------------------
  // Status pass-through
  // ----------------------------------------
  // One register stage only; nothing in this unit may alter a flag,
  // so the byte leaves exactly as it arrived one cycle earlier
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      status_out <= `STATUS_RESET;
    end else begin
      status_out <= status_in;
    end
  end

  // ----------------------------------------
  // Software reset and cause flag
  // ----------------------------------------
  // The flag is cleared here and set again by sys_rst. If the system
  // feeds the reset request straight back into sys_rst the cleared
  // value is lost, so the source must be latched outside this unit.
  reg flag_next;
  reg reset_req_next;

  always @* begin
    flag_next      = soft_reset_cause_flag;
    reset_req_next = 1'b0;
    if (soft_reset_hit) begin
      flag_next      = 1'b0;
      reset_req_next = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      soft_reset_cause_flag <= `CAUSE_RESET;
      device_reset_req      <= 1'b0;
    end else begin
      soft_reset_cause_flag <= flag_next;
      device_reset_req      <= reset_req_next;
    end
  end

  // ----------------------------------------
  // Completion strobe
  // ----------------------------------------
  // Every accepted word, known or not, finishes in a single cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= instr_valid;
    end
  end
endmodule

// >>> rtl/ptr_adjust.v
// Effective address and pointer update calculator
`timescale 1ns/1ps
`include "isx_consts.vh"
module ptr_adjust (
  input  wire [15:0] ptr,
  input  wire [1:0]  pointer_update_code,
  input  wire        use_offset,
  input  wire [5:0]  offset,
  output reg  [15:0] eff_addr,
  output reg  [15:0] ptr_after
);
  reg [15:0] inc;
  reg [15:0] dec;
  always @* begin
    inc = ptr + 16'h0001;
    dec = ptr - 16'h0001;
    eff_addr = ptr;
    ptr_after = ptr;
    if (use_offset) begin
      eff_addr = ptr + {{10{offset[5]}}, offset};
    end else begin
      case (pointer_update_code)
        `MODE_PREINC: begin
          eff_addr = inc;
          ptr_after = inc;
        end
        `MODE_PREDEC: begin
          eff_addr = dec;
          ptr_after = dec;
        end
        `MODE_POSTINC: begin
          ptr_after = inc;
        end
        default: begin
          ptr_after = dec;
        end
      endcase
    end
  end
endmodule

// >>> verif/indirect_store_misc_instr_tb.sv
// Bench for the indirect store unit
`timescale 1ns/1ps
module indirect_store_misc_instr_tb;
  logic ref_clk = 0, sys_rst = 1, instr_valid = 0, ptr_sel = 0, mem_we, done;
  logic device_reset_req, soft_reset_cause_flag;
  logic [2:0] instr_op = 0;
  logic [1:0] pointer_update_code = 0;
  logic [5:0] offset = 0;
  logic [7:0] acc = 0, status_in = 8'ha5, option_reg, status_out, mem_wdata;
  logic [15:0] ptr0, ptr1, mem_addr;
  int mismatches = 0, n_tests = 0;
  indirect_store_misc_instr i_dut (.*);
  always #2 ref_clk = ~ref_clk;
  task chk(input string n, input [15:0] e, g);
    n_tests++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Accumulator is the offset plus 40h, so writes with equal offsets carry the same byte
  task run(input [2:0] o, input p, input [1:0] c, input [5:0] f);
    @(negedge ref_clk);
    {instr_valid, instr_op, ptr_sel, pointer_update_code, offset, acc} =
      {1'b1, o, p, c, f, f + 8'h40};
    @(negedge ref_clk);
    instr_valid = 0;
    chk("done", 16'h0001, done);
  endtask
  task t_ptr;
    run(1, 0, 1, 0);
    chk("addr", 16'hffff, mem_addr);
    chk("data", 8'h40, mem_wdata);
    run(1, 0, 0, 0);
    chk("ptr0", 0, ptr0);
    run(1, 1, 2, 0);
    chk("ptr1", 1, ptr1);
    run(1, 1, 3, 0);
    chk("addr", 1, mem_addr);
    run(3'h1, 1'b0, 2'h3, 6'h00);
    chk("ptr0", 16'hffff, ptr0);
    run(3'h1, 1'b0, 2'h2, 6'h00);
    chk("addr", 16'hffff, mem_addr);
    chk("ptr0", 16'h0000, ptr0);
  endtask
  task t_off;
    run(2, 0, 0, 6'h20);
    chk("addr", 16'hffe0, mem_addr);
    chk("ptr0", 0, ptr0);
  endtask
  task t_misc;
    status_in = 8'h3c;
    run(3, 0, 0, 6'h0f);
    chk("opt", 8'h4f, option_reg);
    chk("stat", 8'h3c, status_out);
    run(0, 0, 0, 0);
    chk("we", 0, mem_we);
    chk("ptr0", 16'h0000, ptr0);
    chk("opt", 16'h004f, option_reg);
    run(3'h7, 1'b0, 2'h0, 6'h00);
    chk("we", 16'h0000, mem_we);
    chk("opt", 16'h004f, option_reg);
    run(4, 0, 0, 0);
    chk("rreq", 1, device_reset_req);
    chk("flag", 0, soft_reset_cause_flag);
  endtask
  task t_rst;
    @(negedge ref_clk);
    sys_rst = 1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    chk("flag", 16'h0001, soft_reset_cause_flag);
    chk("opt", 16'h00ff, option_reg);
  endtask
  task finish_test;
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 0;
    chk("opt", 8'hff, option_reg);
    t_ptr;
    t_off;
    t_misc;
    t_rst;
    finish_test;
  end
  initial begin
    #1000;
    mismatches++;
    finish_test;
  end
endmodule

// >>> verif/isx_checker.sv
// Port checker for the indirect store unit
`timescale 1ns/1ps
module isx_checker (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        instr_valid,
  input wire        ptr_sel,
  input wire        mem_we,
  input wire        device_reset_req,
  input wire        soft_reset_cause_flag,
  input wire        done,
  input wire [2:0]  instr_op,
  input wire [1:0]  pointer_update_code,
  input wire [5:0]  offset,
  input wire [7:0]  acc,
  input wire [7:0]  status_in,
  input wire [7:0]  status_out,
  input wire [7:0]  option_reg,
  input wire [7:0]  mem_wdata,
  input wire [15:0] ptr0,
  input wire [15:0] mem_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire v = instr_valid;
  wire s = v && instr_op == 3'h1 && !ptr_sel;
  wire [15:0] k = {{10{offset[5]}}, offset};
  property p_a; s |=> mem_we && mem_wdata == $past(acc); endproperty
  a_a: assert property (p_a) else $error("store");
  property p_b; s && pointer_update_code == 2'h0 |=> ptr0 == $past(ptr0) + 16'h1
    && mem_addr == ptr0; endproperty
  a_b: assert property (p_b) else $error("preinc");
  property p_c; s && pointer_update_code == 2'h3 |=> ptr0 == $past(ptr0) - 16'h1; endproperty
  a_c: assert property (p_c) else $error("postdec");
  property p_d; v && instr_op == 3'h2 && !ptr_sel |=> mem_addr == $past(ptr0) + $past(k)
    && $stable(ptr0); endproperty
  a_d: assert property (p_d) else $error("offset");
  property p_e; !sys_rst |=> status_out == $past(status_in); endproperty
  a_e: assert property (p_e) else $error("status");
  property p_f; v && instr_op == 3'h3 |=> option_reg == $past(acc); endproperty
  a_f: assert property (p_f) else $error("option");
  property p_g; v && instr_op == 3'h4 |=> device_reset_req; endproperty
  a_g: assert property (p_g) else $error("reset");
  property p_h; v && instr_op == 3'h0 |=> !mem_we && $stable(ptr0); endproperty
  a_h: assert property (p_h) else $error("idle");
  property p_i; v && instr_op == 3'h4 |=> !soft_reset_cause_flag; endproperty
  a_i: assert property (p_i) else $error("cause flag");
  property p_j; !sys_rst |=> done == $past(instr_valid); endproperty
  a_j: assert property (p_j) else $error("done");
endmodule
bind indirect_store_misc_instr isx_checker i_chk (.*);
